/* hdl/rwseq_top.sv */
// Reset and deep-sleep recovery sequencer with AHB-Lite register slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/100ps
`include "rwseq_consts.svh"
module rwseq_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic reset_pin_n,
    input wire logic debug_pin_n,
    input wire logic [7:0] port_pins,
    input wire logic [7:0] wake_enable,
    input wire logic wdt_timeout,
    input wire logic wdt_irq_mode,
    input wire logic irq_enable,
    input wire logic stop_exec,
    input wire logic halt_exec,
    input wire logic cpu_irq,
    output logic cpu_reset,
    output logic sys_reset,
    output logic cpu_run,
    output logic osc_run,
    output logic ipo_select,
    output logic vector_fetch,
    output logic wdt_irq,
    output logic [7:0] port_input_data_register,
    output logic [7:0] watchdog_control_register
);
    logic [1:0] rst_sync;
    logic [1:0] dbg_sync;
    logic [7:0] port_s1;
    logic [7:0] port_s2;
    rwseq_pkg::rwseq_state_t s_r;
    rwseq_pkg::rwseq_state_t s_nxt;
    logic [7:0] cause_byte;
    logic [7:0] status_byte;
    logic rd_cause;
    logic wr_ctrl;
    logic wr_wdctl;
    logic pin_rst;
    logic wake_pin;

    // Hold delay chosen by the crystal enable bit in the control register
    function automatic logic [12:0] hold_len(input logic xtal);
        return xtal ? `RWSEQ_DLY_XTAL : `RWSEQ_DLY_NOXTAL;
    endfunction

    // Two-flop synchronisers for every pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rst_sync <= 2'h3;
            dbg_sync <= 2'h3;
            port_s1 <= 8'h00;
            port_s2 <= 8'h00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], reset_pin_n};
            dbg_sync <= {dbg_sync[0], debug_pin_n};
            port_s1 <= port_pins;
            port_s2 <= port_s1;
        end
    end

    // Cause byte with reserved bits zero
    assign cause_byte = {s_r.cause.por, s_r.cause.stop, s_r.cause.wdt, s_r.cause.pin_reset_flag, 4'h0};
    assign status_byte = {4'h0, s_r.xtal_en, s_r.dbg_req,
                          s_r.mode == rwseq_pkg::RWSEQ_HALT, s_r.mode == rwseq_pkg::RWSEQ_SLEEP};
    assign rd_cause = s_r.ph_act && !s_r.ph_write && s_r.ph_addr == `RWSEQ_ADDR_CAUSE;
    assign wr_wdctl = s_r.ph_act && s_r.ph_write && s_r.ph_addr == `RWSEQ_ADDR_CAUSE;
    assign wr_ctrl = s_r.ph_act && s_r.ph_write && s_r.ph_addr == `RWSEQ_ADDR_CTRL;
    // Filtered pin reset: low for the full glitch window
    assign pin_rst = s_r.glitch == `RWSEQ_GLITCH_CYC;
    assign wake_pin = |((port_s2 ^ s_r.port_last) & wake_enable);

    // Next-state logic for sequencer and bus slave
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.vec_fetch = 1'b0;
        s_nxt.hready = 1'b1;
        s_nxt.glitch = rst_sync[1] ? 2'h0 :
            (pin_rst ? s_r.glitch : 2'(s_r.glitch + 2'h1));
        // Data phase: answered in the cycle after the address phase
        s_nxt.ph_act = 1'b0;
        if (hsel && hready && htrans[1])
        begin
            s_nxt.ph_act = 1'b1;
            s_nxt.ph_write = hwrite;
            s_nxt.ph_addr = haddr[11:0];
            s_nxt.hrdata = 32'h0000_0000;
            if (!hwrite && haddr[11:0] == `RWSEQ_ADDR_CAUSE)
                s_nxt.hrdata = {24'h00_0000, cause_byte};
            else if (!hwrite && haddr[11:0] == `RWSEQ_ADDR_STAT)
                s_nxt.hrdata = {24'h00_0000, status_byte};
            else if (!hwrite && haddr[11:0] == `RWSEQ_ADDR_CTRL)
                s_nxt.hrdata = {28'h000_0000, s_r.xtal_en, s_r.dbg_req, 2'h0};
        end
        // Read clears upper bits; events below override it so a set wins
        if (rd_cause)
            s_nxt.cause = '0;
        if (wr_wdctl)
            s_nxt.wdctl = hwdata[7:0];
        if (wr_ctrl)
        begin
            s_nxt.dbg_req = hwdata[`RWSEQ_BIT_DBGRQ];
            s_nxt.xtal_en = hwdata[`RWSEQ_BIT_XTAL];
            if (hwdata[`RWSEQ_BIT_STOPI] && s_r.mode == rwseq_pkg::RWSEQ_RUN)
                s_nxt.mode = rwseq_pkg::RWSEQ_SLEEP;
            else if (hwdata[`RWSEQ_BIT_HALTI] && s_r.mode == rwseq_pkg::RWSEQ_RUN)
                s_nxt.mode = rwseq_pkg::RWSEQ_HALT;
        end
        if (s_r.wdt_irq_pend && !wdt_irq_mode)
            s_nxt.wdt_irq_pend = 1'b0;
        unique case (s_r.mode)
            rwseq_pkg::RWSEQ_RUN:
            begin
                if (stop_exec)
                    s_nxt.mode = rwseq_pkg::RWSEQ_SLEEP;
                else if (halt_exec)
                    s_nxt.mode = rwseq_pkg::RWSEQ_HALT;
                s_nxt.port_data = port_s2;
                s_nxt.port_last = port_s2;
            end
            rwseq_pkg::RWSEQ_HALT:
            begin
                // Oscillators keep running; cpu_irq, or wdt_timeout in interrupt mode, resumes the CPU
                if (cpu_irq || wdt_timeout)
                    s_nxt.mode = rwseq_pkg::RWSEQ_RUN;
                s_nxt.port_data = port_s2;
                s_nxt.port_last = port_s2;
            end
            rwseq_pkg::RWSEQ_SLEEP:
            begin
                // Input registers frozen while asleep
                s_nxt.port_data = s_r.port_data;
                if (wdt_timeout)
                begin
                    s_nxt.cause = '{por: 1'b0, stop: 1'b1, wdt: 1'b1, pin_reset_flag: s_r.cause.pin_reset_flag};
                    s_nxt.wdt_irq_pend = wdt_irq_mode && irq_enable;
                    s_nxt.mode = rwseq_pkg::RWSEQ_HOLD;
                    s_nxt.recov = 1'b1;
                    s_nxt.cnt = hold_len(s_r.xtal_en);
                end
                else if (wake_pin)
                begin
                    s_nxt.cause = '{por: 1'b0, stop: 1'b1, wdt: 1'b0, pin_reset_flag: 1'b0};
                    s_nxt.mode = rwseq_pkg::RWSEQ_HOLD;
                    s_nxt.recov = 1'b1;
                    s_nxt.cnt = hold_len(s_r.xtal_en);
                end
            end
            rwseq_pkg::RWSEQ_HOLD:
            begin
                if (s_r.cnt > 13'h0001)
                    s_nxt.cnt = 13'(s_r.cnt - 13'h0001);
                else if (!pin_rst)
                begin
                    // Pin still low keeps the part in reset
                    s_nxt.mode = rwseq_pkg::RWSEQ_RUN;
                    s_nxt.sysrst = 1'b0;
                    s_nxt.recov = 1'b0;
                    s_nxt.vec_fetch = 1'b1;
                    s_nxt.port_data = port_s2;
                    s_nxt.port_last = port_s2;
                    if (s_r.recov)
                    begin
                        s_nxt.osc_ipo = 1'b1;
                        s_nxt.wdctl = cause_byte;
                    end
                end
            end
        endcase
        // Awake watchdog reset clears sleep flag, sets only watchdog flag
        if (wdt_timeout && !wdt_irq_mode && s_r.mode != rwseq_pkg::RWSEQ_SLEEP
            && s_r.mode != rwseq_pkg::RWSEQ_HOLD)
        begin
            s_nxt.cause = '{por: 1'b0, stop: 1'b0, wdt: 1'b1, pin_reset_flag: 1'b0};
            s_nxt.mode = rwseq_pkg::RWSEQ_HOLD;
            s_nxt.sysrst = 1'b1;
            s_nxt.recov = 1'b0;
            s_nxt.cnt = hold_len(s_r.xtal_en);
        end
        // System resets outrank every other event
        if (s_r.dbg_req || (!dbg_sync[1] && s_r.mode == rwseq_pkg::RWSEQ_SLEEP))
        begin
            s_nxt.cause = '{por: 1'b1, stop: 1'b0, wdt: 1'b0, pin_reset_flag: 1'b0};
            s_nxt.dbg_req = 1'b0;
            s_nxt.mode = rwseq_pkg::RWSEQ_HOLD;
            s_nxt.sysrst = 1'b1;
            s_nxt.recov = 1'b0;
            s_nxt.osc_ipo = 1'b1;
            s_nxt.cnt = hold_len(s_r.xtal_en);
        end
        if (pin_rst)
        begin
            s_nxt.cause = '{por: 1'b0, stop: 1'b0, wdt: 1'b0, pin_reset_flag: 1'b1};
            s_nxt.mode = rwseq_pkg::RWSEQ_HOLD;
            s_nxt.sysrst = 1'b1;
            s_nxt.recov = 1'b0;
            s_nxt.osc_ipo = 1'b1;
            s_nxt.dbg_req = 1'b0;
            if (s_r.mode != rwseq_pkg::RWSEQ_HOLD || !s_r.sysrst)
                s_nxt.cnt = hold_len(s_r.xtal_en);
        end
    end

    // State register; power-on sets only the power-on flag
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r <= '0;
            s_r.mode <= rwseq_pkg::RWSEQ_HOLD;
            s_r.cause.por <= 1'b1;
            s_r.cnt <= `RWSEQ_DLY_NOXTAL;
            s_r.sysrst <= 1'b1;
            s_r.osc_ipo <= 1'b1;
            s_r.hready <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // All outputs but the tied-off hresp come straight from the state register
    assign hreadyout = s_r.hready;
    assign hresp = 1'b0;
    assign hrdata = s_r.hrdata;
    assign cpu_reset = s_r.mode == rwseq_pkg::RWSEQ_HOLD ? 1'b1 : 1'b0;
    assign sys_reset = s_r.sysrst;
    assign cpu_run = s_r.mode[0];
    assign osc_run = ~s_r.mode[2];
    assign ipo_select = s_r.osc_ipo;
    assign vector_fetch = s_r.vec_fetch;
    assign wdt_irq = s_r.wdt_irq_pend && s_r.mode == rwseq_pkg::RWSEQ_RUN;
    assign port_input_data_register = s_r.port_data;
    assign watchdog_control_register = s_r.wdctl;

    // Recovery hold without crystal lasts at least 8 cycles
    a_hold_length: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(s_r.mode == rwseq_pkg::RWSEQ_HOLD) && !s_r.sysrst && !s_r.xtal_en
        |-> s_r.mode == rwseq_pkg::RWSEQ_HOLD [*8])
        else $error("recovery hold ended early");
    a_read_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_cause && s_r.mode == rwseq_pkg::RWSEQ_RUN && !wdt_timeout && rst_sync[1]
        && !s_r.dbg_req |=> cause_byte == 8'h00)
        else $error("cause not cleared by read");
    a_low_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        cause_byte[3:0] == 4'h0)
        else $error("reserved cause bits set");
    a_dbg_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        s_r.dbg_req && !wr_ctrl |=> !s_r.dbg_req && s_r.sysrst)
        else $error("debug request not taken");
    a_dbg_por: assert property (@(posedge hclk) disable iff (!hresetn)
        s_r.dbg_req && !pin_rst |=> cause_byte == 8'h80)
        else $error("debug reset cause wrong");
    a_wdt_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        s_r.mode == rwseq_pkg::RWSEQ_SLEEP && wdt_timeout && !pin_rst && dbg_sync[1]
        && !s_r.dbg_req |=> s_r.cause.stop && s_r.cause.wdt && !s_r.cause.por)
        else $error("watchdog wake flags wrong");
    a_pin_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        s_r.mode == rwseq_pkg::RWSEQ_SLEEP && wake_pin && !wdt_timeout && !pin_rst
        && dbg_sync[1] && !s_r.dbg_req |=> cause_byte == 8'h40 && cpu_reset)
        else $error("pin wake flags wrong");
    a_vec_fetch: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(vector_fetch) |-> $past(cpu_reset) && cpu_run)
        else $error("vector fetch out of order");
    a_sleep_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
        s_r.mode == rwseq_pkg::RWSEQ_SLEEP |=> $stable(port_input_data_register))
        else $error("port data changed asleep");
endmodule // rwseq_top

/* hdl/rwseq_consts.svh */
// Constants for the reset and wake sequencer
`ifndef RWSEQ_CONSTS_SVH
`define RWSEQ_CONSTS_SVH
`define RWSEQ_ADDR_CAUSE 12'hff0
`define RWSEQ_ADDR_CTRL 12'hff4
`define RWSEQ_ADDR_STAT 12'hff8
`define RWSEQ_DLY_NOXTAL 13'h0042
`define RWSEQ_DLY_XTAL 13'h1388
`define RWSEQ_GLITCH_CYC 2'h3
`define RWSEQ_VEC_LO 16'h0002
`define RWSEQ_VEC_HI 16'h0003
`define RWSEQ_BIT_POR 7
`define RWSEQ_BIT_STOP 6
`define RWSEQ_BIT_WDT 5
`define RWSEQ_BIT_EXT 4
`define RWSEQ_BIT_STOPI 0
`define RWSEQ_BIT_HALTI 1
`define RWSEQ_BIT_DBGRQ 2
`define RWSEQ_BIT_XTAL 3
`endif

/* hdl/rwseq_pkg.sv */
// Types for the reset and wake sequencer
package rwseq_pkg;
    typedef enum logic [3:0] {
        RWSEQ_RUN = 4'b0001,
        RWSEQ_HALT = 4'b0010,
        RWSEQ_SLEEP = 4'b0100,
        RWSEQ_HOLD = 4'b1000
    } rwseq_mode_t;
    typedef struct packed {
        logic por;
        logic stop;
        logic wdt;
        logic pin_reset_flag;
    } rwseq_cause_t;
    typedef struct packed {
        rwseq_mode_t mode;
        rwseq_cause_t cause;
        logic [12:0] cnt;
        logic sysrst;
        logic recov;
        logic wdt_irq_pend;
        logic dbg_req;
        logic xtal_en;
        logic [1:0] glitch;
        logic [7:0] port_last;
        logic [7:0] port_data;
        logic [1:0] wdt_reg;
        logic osc_ipo;
        logic [7:0] wdctl;
        logic vec_fetch;
        logic hready;
        logic [31:0] hrdata;
        logic ph_act;
        logic ph_write;
        logic [11:0] ph_addr;
    } rwseq_state_t;
endpackage

/* bench/rwseq_pins.sv */
// Pin-side model: reset and debug pins with pull-ups, and wake pins
`timescale 1ns/100ps
module rwseq_pins (
    input wire logic hclk,
    output logic reset_pin_n,
    output logic debug_pin_n,
    output logic [7:0] port_pins
);
    // Reset and debug pins sit at their pull-up level; port pins start low
    initial
    begin
        reset_pin_n = 1'b1;
        debug_pin_n = 1'b1;
        port_pins = 8'h00;
    end
    // Hold one pin low for n clocks, then release it
    task automatic pull_low(input bit dbg, input int n);
        @(posedge hclk);
        if (dbg)
            debug_pin_n <= 1'b0;
        else
            reset_pin_n <= 1'b0;
        repeat (n) @(posedge hclk);
        debug_pin_n <= 1'b1;
        reset_pin_n <= 1'b1;
    endtask
    // Either direction of change counts as a wake event
    task automatic flip(input int i);
        @(posedge hclk);
        port_pins[i] <= ~port_pins[i];
    endtask
endmodule // rwseq_pins

/* bench/tb_reset_wake_sequencer.sv */
// Self-checking bench for the reset and wake sequencer
`timescale 1ns/100ps
module tb_reset_wake_sequencer;
    logic hclk, hresetn, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic hsel;
    logic [2:0] hsize;
    logic reset_pin_n, debug_pin_n;
    logic [7:0] port_pins, wake_enable, port_q, wdctl_q;
    logic wdt_timeout, wdt_irq_mode, irq_enable, stop_exec, halt_exec, cpu_irq;
    logic cpu_reset, sys_reset, cpu_run, osc_run, ipo_select, vector_fetch, wdt_irq;
    int err_count, n_compared, cyc;

    // Single slave, so its ready is the bus ready
    rwseq_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .reset_pin_n(reset_pin_n), .debug_pin_n(debug_pin_n), .port_pins(port_pins),
        .wake_enable(wake_enable), .wdt_timeout(wdt_timeout), .wdt_irq_mode(wdt_irq_mode),
        .irq_enable(irq_enable), .stop_exec(stop_exec), .halt_exec(halt_exec),
        .cpu_irq(cpu_irq), .cpu_reset(cpu_reset), .sys_reset(sys_reset), .cpu_run(cpu_run),
        .osc_run(osc_run), .ipo_select(ipo_select), .vector_fetch(vector_fetch),
        .wdt_irq(wdt_irq), .port_input_data_register(port_q),
        .watchdog_control_register(wdctl_q));
    rwseq_pins u_pins (.hclk(hclk), .reset_pin_n(reset_pin_n), .debug_pin_n(debug_pin_n),
        .port_pins(port_pins));

    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Hang guard: the longest hold is 5000 cycles, the whole run far less than this
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One AHB single transfer; waits on ready in both phases
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        htrans <= 2'b10;
        hsel <= 1'b1;
        hsize <= 3'b010;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk(hresp, 1'b0);
    endtask
    task automatic pulse(input int which);
        @(posedge hclk);
        if (which == 0)
            stop_exec <= 1'b1;
        else if (which == 1)
            halt_exec <= 1'b1;
        else
            wdt_timeout <= 1'b1;
        @(posedge hclk);
        stop_exec <= 1'b0;
        halt_exec <= 1'b0;
        wdt_timeout <= 1'b0;
    endtask
    task automatic sleep();
        pulse(0);
        repeat (3) @(posedge hclk);
        chk(osc_run, 1'b0);
        chk(cpu_run, 1'b0);
    endtask
    // Count the held cycles up to the vector fetch pulse; exp 0 skips the count
    task automatic wake_wait(input int exp);
        int hold;
        hold = 0;
        for (int i = 0; i < 6000 && vector_fetch !== 1'b1; i++)
        begin
            @(posedge hclk);
            if (cpu_reset === 1'b1)
                hold++;
        end
        chk(vector_fetch, 1'b1);
        if (exp > 0)
            chk(hold, exp);
        repeat (2) @(posedge hclk);
        chk(ipo_select, 1'b1);
    endtask
    task automatic t_por();
        rdc(32'h0000_0ff0, 32'h0000_0080);
        rdc(32'h0000_0ff0, 32'h0000_0000);
        xfer(1'b1, 32'h0000_0ff0, 32'h0000_005a);
        // The write lands at the data-phase edge; look one edge later
        @(posedge hclk);
        chk(wdctl_q, 8'h5a);
        rdc(32'h0000_0ff0, 32'h0000_0000);
        rdc(32'h0000_0100, 32'h0000_0000);
        $display("por test done");
    endtask
    // Disabled pin must not wake; enabled pin wakes on both edges
    task automatic t_pin();
        for (int k = 0; k < 2; k++)
        begin
            // Pin 0 stays disabled; idle pins 1 and 7 join the second pass
            wake_enable <= k ? 8'h8a : 8'h08;
            sleep();
            u_pins.flip(0);
            repeat (10) @(posedge hclk);
            chk(osc_run, 1'b0);
            u_pins.flip(3);
            wake_wait(66);
            chk(port_q[3], port_pins[3]);
            rdc(32'h0000_0ff0, 32'h0000_0040);
        end
        $display("pin wake test done");
    endtask
    task automatic t_wdt();
        wdt_irq_mode <= 1'b1;
        irq_enable <= 1'b1;
        sleep();
        pulse(2);
        wake_wait(66);
        repeat (2) @(posedge hclk);
        chk(wdt_irq, 1'b1);
        rdc(32'h0000_0ff0, 32'h0000_0060);
        wdt_irq_mode <= 1'b0;
        sleep();
        pulse(2);
        wake_wait(66);
        sleep();
        u_pins.flip(3);
        wake_wait(66);
        rdc(32'h0000_0ff0, 32'h0000_0040);
        $display("watchdog wake test done");
    endtask
    // A one-cycle glitch is filtered; a long low in sleep resets the chip
    task automatic t_ext();
        u_pins.pull_low(1'b0, 1);
        repeat (8) @(posedge hclk);
        chk(sys_reset, 1'b0);
        sleep();
        u_pins.pull_low(1'b0, 10);
        wake_wait(0);
        rdc(32'h0000_0ff0, 32'h0000_0010);
        u_pins.pull_low(1'b0, 10);
        wake_wait(0);
        sleep();
        u_pins.flip(3);
        wake_wait(66);
        rdc(32'h0000_0ff0, 32'h0000_0040);
        $display("reset pin test done");
    endtask
    task automatic t_dbg();
        sleep();
        u_pins.pull_low(1'b1, 10);
        wake_wait(0);
        rdc(32'h0000_0ff0, 32'h0000_0080);
        xfer(1'b1, 32'h0000_0ff4, 32'h0000_0004);
        wake_wait(0);
        rdc(32'h0000_0ff8, 32'h0000_0000);
        rdc(32'h0000_0ff0, 32'h0000_0080);
        xfer(1'b1, 32'h0000_0ff4, 32'h0000_0004);
        wake_wait(0);
        sleep();
        u_pins.flip(3);
        wake_wait(66);
        rdc(32'h0000_0ff0, 32'h0000_0040);
        $display("debug test done");
    endtask
    task automatic t_halt();
        pulse(1);
        repeat (3) @(posedge hclk);
        chk(cpu_run, 1'b0);
        chk(osc_run, 1'b1);
        cpu_irq <= 1'b1;
        for (int i = 0; i < 20 && cpu_run !== 1'b1; i++) @(posedge hclk);
        chk(cpu_run, 1'b1);
        cpu_irq <= 1'b0;
        $display("halt test done");
    endtask
    task automatic t_xtal();
        xfer(1'b1, 32'h0000_0ff4, 32'h0000_0008);
        sleep();
        u_pins.flip(3);
        wake_wait(5000);
        $display("crystal hold test done");
    endtask

    initial
    begin
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        hresetn = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'b00;
        hsel = 1'b0;
        hsize = 3'b000;
        hwrite = 1'b0;
        wake_enable = 8'h08;
        {wdt_timeout, wdt_irq_mode, irq_enable, stop_exec, halt_exec, cpu_irq} = 6'h00;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        wake_wait(66);
        t_por();
        t_pin();
        t_wdt();
        t_ext();
        t_dbg();
        t_halt();
        t_xtal();
        print_verdict();
    end
endmodule // tb_reset_wake_sequencer
